//--- include/fom_map.vh
// Constants of the fieldbus object mapper: register addresses, field positions and codes.
`ifndef FOM_MAP_VH
`define FOM_MAP_VH

// -----------------------------------------------------------------------------
// Object index translation
// -----------------------------------------------------------------------------
`define FOM_INDEX_BASE      16'h2001
`define FOM_ADDR_NOM_VOLT   16'h0079
`define FOM_ADDR_REMOTE     16'h0192
`define FOM_ADDR_STATUS     16'h01F9
`define FOM_ADDR_MEAS_VOLT  16'h01FB
`define FOM_ADDR_MEAS_CURR  16'h01FC
`define FOM_ADDR_MEAS_POW   16'h01FD

// -----------------------------------------------------------------------------
// Remote control codes
// -----------------------------------------------------------------------------
`define FOM_REMOTE_ENTER    16'hFF00
`define FOM_REMOTE_LEAVE    16'h0000

// -----------------------------------------------------------------------------
// Status word fields
// -----------------------------------------------------------------------------
`define FOM_ST_MASTER_BIT   6
`define FOM_ST_POWER_BIT    7
`define FOM_ST_CC_BIT       10

// -----------------------------------------------------------------------------
// Scaling
// -----------------------------------------------------------------------------
`define FOM_FULL_SCALE      16'hCCCC
`define FOM_FRAC_BITS       16

// -----------------------------------------------------------------------------
// Cyclic image layout, slot one in the top bits
// -----------------------------------------------------------------------------
`define FOM_IMG_W           144
`define FOM_IMG_STATUS_HI   143
`define FOM_IMG_STATUS_LO   112
`define FOM_IMG_VOLT_HI     111
`define FOM_IMG_VOLT_LO     96
`define FOM_IMG_CURR_HI     95
`define FOM_IMG_CURR_LO     80
`define FOM_IMG_POW_HI      79
`define FOM_IMG_POW_LO      64
`define FOM_IMG_SPARE_HI    63
`define FOM_IMG_SPARE_LO    0
`define FOM_IMG_SPARE_W     64

`endif

//--- verilog/fom_scale.v
// Scaler that turns a fraction of nominal rating into the 52428-step fieldbus word.
`timescale 1ns/1ps
`include "fom_map.vh"
module fom_scale (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire [15:0] frac_i,
  output wire [15:0] word_o
);

  reg  [15:0] word_q;
  wire [31:0] prod;

  // The fraction is Q0.16 of nominal, so the word tops out just below full scale.
  assign prod = frac_i * `FOM_FULL_SCALE;

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_q <= 16'h0000;
    end else begin
      word_q <= prod[31:`FOM_FRAC_BITS];
    end
  end

  assign word_o = word_q;

endmodule // fom_scale

//--- verilog/fom_mapper.v
// Fieldbus object mapper: cyclic input image and indexed object access to load registers.
`timescale 1ns/1ps
`include "fom_map.vh"
module fom_mapper (
  input  wire                  sys_clk_i,
  input  wire                  sys_rst_i,
  // Load state, from logic on the same clock.
  input  wire [31:0]           status_word_i,
  input  wire                  master_config_i,
  input  wire                  power_stage_on_i,
  input  wire                  constant_current_regulation_i,
  input  wire [15:0]           volt_frac_i,
  input  wire [15:0]           curr_frac_i,
  input  wire [15:0]           pow_frac_i,
  input  wire [31:0]           nominal_voltage_i,
  // Object access from the fieldbus side.
  input  wire                  obj_req_i,
  input  wire                  obj_wr_i,
  input  wire [15:0]           obj_index_i,
  input  wire [31:0]           obj_wdata_i,
  output wire                  obj_ack_o,
  output wire                  obj_err_o,
  output wire [31:0]           obj_rdata_o,
  // Remote control state and cyclic image.
  output wire                  remote_mode_o,
  output wire [`FOM_IMG_W-1:0] cyc_image_o
);

  // ---------------------------------------------------------------------------
  // Status word and scaled measurements
  // ---------------------------------------------------------------------------
  reg  [31:0]           status_q;
  reg  [31:0]           status_d;
  wire [15:0]           volt_word;
  wire [15:0]           curr_word;
  wire [15:0]           pow_word;

  // The three flag bits follow their dedicated inputs so they cannot disagree with the regulator.
  always @* begin
    status_d                      = status_word_i;
    status_d[`FOM_ST_MASTER_BIT]  = master_config_i;
    status_d[`FOM_ST_POWER_BIT]   = power_stage_on_i;
    status_d[`FOM_ST_CC_BIT]      = constant_current_regulation_i;
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Scaled measurements
  // ---------------------------------------------------------------------------
  // Each measured word lags its fraction input by one cycle.
  fom_scale u_scale_volt (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .frac_i    (volt_frac_i),
    .word_o    (volt_word)
  );

  fom_scale u_scale_curr (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .frac_i    (curr_frac_i),
    .word_o    (curr_word)
  );

  fom_scale u_scale_pow (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .frac_i    (pow_frac_i),
    .word_o    (pow_word)
  );

  // ---------------------------------------------------------------------------
  // Cyclic image
  // ---------------------------------------------------------------------------
  // Slot one occupies the top bits so that it leaves first on the wire.
  wire [`FOM_IMG_SPARE_W-1:0] spare_slots;

  assign spare_slots = {`FOM_IMG_SPARE_W{1'b0}};
  assign cyc_image_o[`FOM_IMG_STATUS_HI:`FOM_IMG_STATUS_LO] = status_q;
  assign cyc_image_o[`FOM_IMG_VOLT_HI:`FOM_IMG_VOLT_LO]     = volt_word;
  assign cyc_image_o[`FOM_IMG_CURR_HI:`FOM_IMG_CURR_LO]     = curr_word;
  assign cyc_image_o[`FOM_IMG_POW_HI:`FOM_IMG_POW_LO]       = pow_word;
  assign cyc_image_o[`FOM_IMG_SPARE_HI:`FOM_IMG_SPARE_LO]   = spare_slots;

  // ---------------------------------------------------------------------------
  // Object index translation
  // ---------------------------------------------------------------------------
  wire [15:0]           addr;
  wire                  sel_nom;
  wire                  sel_remote;
  wire                  sel_status;
  wire                  sel_volt;
  wire                  sel_curr;
  wire                  sel_pow;
  wire                  hit;

  // The subtraction wraps, so indexes below the base land on high addresses that decode as unmapped.
  assign addr       = obj_index_i - `FOM_INDEX_BASE;
  assign sel_nom    = (addr == `FOM_ADDR_NOM_VOLT);
  assign sel_remote = (addr == `FOM_ADDR_REMOTE);
  assign sel_status = (addr == `FOM_ADDR_STATUS);
  assign sel_volt   = (addr == `FOM_ADDR_MEAS_VOLT);
  assign sel_curr   = (addr == `FOM_ADDR_MEAS_CURR);
  assign sel_pow    = (addr == `FOM_ADDR_MEAS_POW);
  // Any index outside the six mapped registers is refused.
  assign hit        = sel_nom | sel_remote | sel_status | sel_volt | sel_curr | sel_pow;

  // ---------------------------------------------------------------------------
  // Write checks
  // ---------------------------------------------------------------------------
  wire                  enter_code;
  wire                  leave_code;
  wire                  bad_wr;
  wire                  accept;
  wire                  rd_take;
  wire                  remote_wr;

  assign enter_code = (obj_wdata_i[15:0] == `FOM_REMOTE_ENTER);
  assign leave_code = (obj_wdata_i[15:0] == `FOM_REMOTE_LEAVE);
  // Only the remote register is writable, and only with one of its two codes.
  assign bad_wr     = obj_wr_i & ~(sel_remote & (enter_code | leave_code));
  // A request is accepted when it maps to a register and is not a refused write.
  assign accept     = obj_req_i & hit & ~bad_wr;
  // Read data is captured only on accepted reads, so a refused access leaves it unchanged.
  assign rd_take    = accept & ~obj_wr_i;
  assign remote_wr  = accept & obj_wr_i & sel_remote;

  // ---------------------------------------------------------------------------
  // Read data select
  // ---------------------------------------------------------------------------
  reg  [31:0]           rd_val;
  reg                   remote_d;
  reg                   remote_q;
  reg                   ack_q;
  reg                   err_q;
  reg  [31:0]           rdata_q;
  wire [15:0]           remote_code;

  // The remote register reads back the code that selects the present mode.
  assign remote_code = remote_q ? `FOM_REMOTE_ENTER : `FOM_REMOTE_LEAVE;

  // Sixteen-bit registers return their value in the low half with the upper half zero.
  always @* begin
    rd_val = 32'h0000_0000;
    if (sel_nom) begin
      rd_val = nominal_voltage_i;
    end else if (sel_remote) begin
      rd_val = {16'h0000, remote_code};
    end else if (sel_status) begin
      rd_val = status_q;
    end else if (sel_volt) begin
      rd_val = {16'h0000, volt_word};
    end else if (sel_curr) begin
      rd_val = {16'h0000, curr_word};
    end else if (sel_pow) begin
      rd_val = {16'h0000, pow_word};
    end
  end

  // ---------------------------------------------------------------------------
  // Remote control state
  // ---------------------------------------------------------------------------
  // A refused write leaves the remote state untouched.
  always @* begin
    remote_d = remote_q;
    if (remote_wr) begin
      remote_d = enter_code;
    end
  end

  // ---------------------------------------------------------------------------
  // Answer registers
  // ---------------------------------------------------------------------------
  // Ack and err stand one cycle; read data holds until the next accepted read.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      remote_q <= 1'b0;
    end else begin
      remote_q <= remote_d;
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= accept;
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= obj_req_i & ~accept;
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= rd_val;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign obj_ack_o     = ack_q;
  assign obj_err_o     = err_q;
  assign obj_rdata_o   = rdata_q;
  assign remote_mode_o = remote_q;

endmodule // fom_mapper

//--- tb/fom_mapper_sva.sv
// Assertions on the object port and cyclic image of the object mapper.
`timescale 1ns/1ps
module fom_mapper_sva (
  input wire         sys_clk_i,
  input wire         sys_rst_i,
  input wire [31:0]  status_word_i,
  input wire         master_config_i,
  input wire [15:0]  volt_frac_i,
  input wire [31:0]  nominal_voltage_i,
  input wire         obj_req_i,
  input wire         obj_wr_i,
  input wire [15:0]  obj_index_i,
  input wire [31:0]  obj_wdata_i,
  input wire         obj_ack_o,
  input wire         obj_err_o,
  input wire [31:0]  obj_rdata_o,
  input wire         remote_mode_o,
  input wire [143:0] cyc_image_o
);
  reg  [1:0] up_q;
  wire       mapped = obj_index_i inside {16'h207A, 16'h2193, 16'h21FA, [16'h21FC:16'h21FE]};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  function [15:0] sc(input [15:0] f);
    reg [31:0] p;
    begin
      p = f * 32'h0000CCCC;
      sc = p[31:16];
    end
  endfunction
  always @(posedge sys_clk_i or posedge sys_rst_i)
    if (sys_rst_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  chk_spare_zero: assert property (cyc_image_o[63:0] == 64'h0)
    else $error("spare slots not zero");
  chk_status_word: assert property (up_q == 2'h3 |->
    (cyc_image_o[143:112] & 32'hFFFFFB3F) == ($past(status_word_i) & 32'hFFFFFB3F)) else $error("status slot wrong");
  chk_master_bit: assert property (up_q == 2'h3 |-> cyc_image_o[118] == $past(master_config_i))
    else $error("master bit wrong");
  chk_volt_scale: assert property (up_q == 2'h3 |-> cyc_image_o[111:96] == sc($past(volt_frac_i)))
    else $error("voltage word wrong");
  chk_one_answer: assert property (obj_req_i |=> obj_ack_o != obj_err_o)
    else $error("not exactly one answer");
  chk_idle_quiet: assert property (!obj_req_i |=> !obj_ack_o && !obj_err_o)
    else $error("answer without request");
  chk_remote_enter: assert property (obj_req_i && obj_wr_i && obj_index_i == 16'h2193 &&
    obj_wdata_i[15:0] == 16'hFF00 |=> remote_mode_o && obj_ack_o) else $error("remote entry failed");
  chk_unmapped_err: assert property (obj_req_i && !mapped |=> obj_err_o && $stable(remote_mode_o))
    else $error("unmapped index accepted");
  chk_nominal_read: assert property (obj_req_i && !obj_wr_i && obj_index_i == 16'h207A |=>
    obj_ack_o && obj_rdata_o == $past(nominal_voltage_i)) else $error("nominal read wrong");
endmodule // fom_mapper_sva
bind fom_mapper fom_mapper_sva chk_u (.sys_clk_i, .sys_rst_i, .status_word_i, .master_config_i, .volt_frac_i,
  .nominal_voltage_i, .obj_req_i, .obj_wr_i, .obj_index_i, .obj_wdata_i, .obj_ack_o, .obj_err_o, .obj_rdata_o,
  .remote_mode_o, .cyc_image_o);

//--- tb/fom_fb_master.sv
// Fieldbus master model that issues single object accesses.
`timescale 1ns/1ps
module fom_fb_master (
  input  wire        sys_clk_i,
  input  wire        obj_ack_i,
  input  wire        obj_err_i,
  input  wire [31:0] obj_rdata_i,
  output reg         obj_req_o = 1'b0,
  output reg         obj_wr_o = 1'b0,
  output reg  [15:0] obj_index_o = 16'h0,
  output reg  [31:0] obj_wdata_o = 32'h0
);
  // Each access holds the request for one cycle and samples the answer at the next falling edge; afterwards index and data carry their inverse.
  task access(input w, input [15:0] idx, input [31:0] wd, output [1:0] ans, output [31:0] rd);
    begin
      @(negedge sys_clk_i);
      obj_req_o <= 1'b1;
      obj_wr_o <= w;
      obj_index_o <= idx;
      obj_wdata_o <= wd;
      @(negedge sys_clk_i);
      ans = {obj_ack_i, obj_err_i};
      rd = obj_rdata_i;
      obj_req_o <= 1'b0;
      obj_index_o <= ~idx;
      obj_wdata_o <= ~wd;
    end
  endtask
endmodule // fom_fb_master

//--- tb/fom_mapper_tb.sv
// Self-checking bench for the fieldbus object mapper.
`timescale 1ns/1ps
module fom_mapper_tb;
  reg          sys_clk_i = 1'b0;
  reg          sys_rst_i = 1'b1;
  reg  [31:0]  status_word_i = 32'h0;
  reg  [2:0]   flags = 3'h0;
  reg  [15:0]  vf = 16'h0, cf = 16'h0, pf = 16'h0;
  reg  [31:0]  nominal_voltage_i = 32'h437A0000;
  wire         req, wr, ack, err, remote;
  wire [15:0]  idx;
  wire [31:0]  wdata, rdata;
  wire [143:0] img;
  reg  [1:0]   ans;
  reg  [31:0]  rd, held;
  integer      failures = 0, num_checks = 0, cycles = 0, remote_m = 0, i, s;
  int          addrs [$] = '{121, 402, 505, 507, 508, 509};
  fom_mapper dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .status_word_i(status_word_i),
    .master_config_i(flags[0]), .power_stage_on_i(flags[1]), .constant_current_regulation_i(flags[2]),
    .volt_frac_i(vf), .curr_frac_i(cf), .pow_frac_i(pf), .nominal_voltage_i(nominal_voltage_i),
    .obj_req_i(req), .obj_wr_i(wr), .obj_index_i(idx), .obj_wdata_i(wdata), .obj_ack_o(ack),
    .obj_err_o(err), .obj_rdata_o(rdata), .remote_mode_o(remote), .cyc_image_o(img));
  fom_fb_master master_u (.sys_clk_i(sys_clk_i), .obj_ack_i(ack), .obj_err_i(err), .obj_rdata_i(rdata),
    .obj_req_o(req), .obj_wr_o(wr), .obj_index_o(idx), .obj_wdata_o(wdata));
  function [15:0] sc(input longint f);
    sc = 16'(f * 52428 / 65536);
  endfunction
  function [31:0] exp_reg(input integer a);
    case (a)
      121: exp_reg = nominal_voltage_i;
      402: exp_reg = remote_m ? 32'h0000FF00 : 32'h0;
      505: exp_reg = {status_word_i[31:11], flags[2], status_word_i[9:8], flags[1:0], status_word_i[5:0]};
      507: exp_reg = {16'h0, sc(vf)};
      508: exp_reg = {16'h0, sc(cf)};
      default: exp_reg = {16'h0, sc(pf)};
    endcase
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task obj(input w, input integer a, input [31:0] wd, input [1:0] exp_ans);
    begin
      master_u.access(w, 16'(a + 32'h2001), wd, ans, rd);
      if (exp_ans == 2'b10 && !w) held = exp_reg(a);
      if (exp_ans == 2'b10 && w) remote_m = (wd[15:0] == 16'hFF00);
      check(ans, exp_ans);
      check(rd, held);
      check(remote, remote_m);
    end
  endtask
  task results;
    begin
      if (failures == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      failures = failures + 1;
      results();
    end
  end
  initial begin
    s = $urandom(32'h0EF21D87);
    held = 32'h0;
    repeat (2) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    check(rdata, 32'h0);
    for (i = 0; i < 24; i = i + 1) begin
      @(negedge sys_clk_i);
      vf = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8000 : 16'($urandom);
      cf = (i == 0) ? 16'h0 : 16'($urandom);
      pf = 16'($urandom);
      status_word_i = $urandom;
      flags = 3'($urandom);
      repeat (2) @(negedge sys_clk_i);
      check(img[143:112], exp_reg(505));
      check(img[111:96], exp_reg(507));
      check(img[95:80], exp_reg(508));
      check(img[79:64], exp_reg(509));
      check(img[63:32] | img[31:0], 32'h0);
      obj(0, addrs[i % 6], 32'h0, 2'b10);
    end
    obj(1, 402, 32'h0000FF00, 2'b10);
    obj(0, 402, 32'h0, 2'b10);
    obj(1, 402, 32'h00001234, 2'b01);
    obj(1, 505, 32'h0, 2'b01);
    obj(1, 121, 32'h3F800000, 2'b01);
    obj(0, 32'h0FFF, 32'h0, 2'b01);
    obj(0, -1, 32'h0, 2'b01);
    obj(1, 402, 32'h0, 2'b10);
    obj(0, 402, 32'h0, 2'b10);
    results();
  end
endmodule // fom_mapper_tb
